// ==== hdl/serial_eeprom_idpage_access.sv ====
// Purpose: SPI-side handling of a 64-byte lockable identification page
// Assumes: SPI mode 0; spiClk stops outside frames; csN high holds link logic in reset
// Notes: Page and lock bit change only at the end of a write cycle, while reads are
//        refused, so the link domain may read them as quasi-static data
//
// Notes on behaviour
// - Page read: opcode, two address bytes, then page byte at low six bits out
// - Extra 64-byte page, writable, and permanently lockable to read-only
// - During a page read the address steps after each byte; any start byte allowed
// - Chip select rising ends a read anywhere; output stops at once
// - Page read and lock-state read refused while a write cycle runs
// - Accepted page write starts the timed write cycle at chip select rise
// - Writes to the first three bytes replace the identification code
// - Write and lock discarded if busy, both guard bits set, or framing bad
// - Lock-state byte has bit 0 set when locked, clear when unlocked
// - Lock-state byte repeats while chip select stays low, no stepping
// - Lock executes only if chip select rises on a data-byte boundary
// - Valid lock starts a timed write cycle that makes the page read-only
// - Arm, write and lock ignored until supply good, reads are not; then idle, arm and busy flags clear
// - Only a selected device drives data out; otherwise output released
// - Page read and lock-state read share an opcode; select bit decides
// - Page write and lock share an opcode; select bit decides
`timescale 1ns/1ps
module serial_eeprom_idpage_access
  import seia_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_TIME_CYCLES,
  parameter logic [23:0] DEVICE_ID_CODE = 24'h5aa53c // Arbitrary value
)(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic spiClk,
  input wire logic csN,
  input wire logic sdi,
  output logic sdo,
  output logic sdoOe,
  input wire logic supplyOk,
  input wire logic blockGuardHi,
  input wire logic blockGuardLo,
  output logic writeLatchFlag,
  output logic busyFlag,
  output logic pageLocked
);

  // Delivery state: identification code in front, erased bytes behind
  function automatic seia_page_type seiaDeliveryPage(input logic [23:0] code);
    seia_page_type img;
    for (int k = 0; k < PAGE_BYTES; k++) begin
      img[k] = ERASED_BYTE;
    end
    for (int k = 0; k < ID_CODE_BYTES; k++) begin
      img[k] = code[(ID_CODE_BYTES-1-k)*BYTE_W +: BYTE_W];
    end
    return img;
  endfunction : seiaDeliveryPage

  // Non-volatile contents: kept across sys_rst, defined from power-up
  seia_page_type page_r = seiaDeliveryPage(DEVICE_ID_CODE);
  logic locked_r = LOCK_DELIVERY;

  // Link domain state
  seia_link_state_type linkState_r;
  logic [2:0] bitCnt_r;
  logic [6:0] shift_r;
  logic addrSecond_r;
  logic [7:0] addrHi_r;
  logic [PAGE_AW-1:0] addrCnt_r;
  logic isWriteOp_r;
  logic busyLinkS1_r;
  logic busyLinkS2_r;
  logic [7:0] rxByte;
  logic byteDone;
  logic [7:0] rdByte;
  logic sdo_r;
  logic sdoOe_r;

  // Frame summary: survives chip select rise so mclk can judge the frame
  seia_frame_kind_type frameKind_r = FK_NONE;
  logic frameTag_r = 1'b0;
  logic alignedEnd_r = 1'b0;
  logic dataSeen_r = 1'b0;
  logic lockData_r = 1'b0;

  // mclk domain state
  seia_ctl_state_type ctlState_r;
  logic csS1_r;
  logic csS2_r;
  logic csPrev_r;
  logic supS1_r;
  logic supS2_r;
  logic tagS1_r;
  logic tagS2_r;
  logic tagSeen_r;
  logic frameOk_r;
  logic [2:0] settleCnt_r;
  logic wel_r;
  logic progLock_r;
  logic startProg;
  logic timerBusy;
  logic timerDone;
  logic csRise;
  logic csFall;
  logic frameValid;
  logic guardAll;
  logic acceptWrite;
  logic acceptLock;
  logic acceptArm;
  logic commitPage;
  logic maskClear;
  logic stageWr;
  logic [BYTE_W-1:0] pend_r [PAGE_BYTES];
  logic pendMask_r [PAGE_BYTES];

  seia_xfer_if xfer ();

  // ---- Link domain (spiClk) ----

  assign rxByte = {shift_r, sdi};
  assign byteDone = (bitCnt_r == BIT_TOP);

  // Command decoder; csN high clears it between frames
  always_ff @(posedge spiClk or posedge csN) begin
    if (csN) begin
      linkState_r <= LS_OPCODE;
      bitCnt_r <= 3'h0;
      shift_r <= 7'h00;
      addrSecond_r <= 1'b0;
      addrHi_r <= 8'h00;
      addrCnt_r <= '0;
      isWriteOp_r <= 1'b0;
    end else begin
      bitCnt_r <= bitCnt_r + 3'h1;
      shift_r <= rxByte[6:0]; // MSB first
      if (byteDone) begin
        unique case (linkState_r)
          LS_OPCODE: begin
            if (busyLinkS2_r) begin
              linkState_r <= LS_IGNORE; // Refused during write cycle
            end else if (rxByte == OPC_IDPAGE_READ) begin
              linkState_r <= LS_ADDR;
              isWriteOp_r <= 1'b0;
            end else if (rxByte == OPC_IDPAGE_WRITE) begin
              linkState_r <= LS_ADDR;
              isWriteOp_r <= 1'b1;
            end else begin
              linkState_r <= LS_IGNORE;
            end
          end
          LS_ADDR: begin
            if (!addrSecond_r) begin
              addrHi_r <= rxByte;
              addrSecond_r <= 1'b1;
            end else begin
              // Only the low six bits address the page
              addrCnt_r <= rxByte[PAGE_AW-1:0];
              if (isWriteOp_r) begin
                linkState_r <= LS_WRDATA; // Write or lock by select bit
              end else if (addrHi_r[SPACE_SEL_HI_POS]) begin
                linkState_r <= LS_RDLOCK; // Other address bits ignored
              end else begin
                linkState_r <= LS_RDPAGE;
              end
            end
          end
          LS_RDPAGE: begin
            addrCnt_r <= addrCnt_r + 1'b1; // Step to next byte
          end
          LS_RDLOCK: begin
            linkState_r <= LS_RDLOCK; // Same byte again
          end
          LS_WRDATA: begin
            addrCnt_r <= addrCnt_r + 1'b1;
          end
          LS_IGNORE: begin
            linkState_r <= LS_IGNORE;
          end
          default: begin
            linkState_r <= LS_IGNORE;
          end
        endcase
      end
    end
  end

  // Busy level into the link domain; settles well before the opcode ends
  always_ff @(posedge spiClk or posedge csN) begin
    if (csN) begin
      busyLinkS1_r <= 1'b1;
      busyLinkS2_r <= 1'b1;
    end else begin
      busyLinkS1_r <= timerBusy;
      busyLinkS2_r <= busyLinkS1_r;
    end
  end

  // Frame summary; the tag flip tells mclk that this frame had clock edges
  always_ff @(posedge spiClk) begin
    alignedEnd_r <= byteDone; // True if the frame stops here
    if (linkState_r == LS_OPCODE && bitCnt_r == 3'h0) begin
      frameTag_r <= ~frameTag_r;
      frameKind_r <= FK_NONE;
      dataSeen_r <= 1'b0;
      lockData_r <= 1'b0;
    end else if (byteDone) begin
      if (linkState_r == LS_OPCODE && !busyLinkS2_r && rxByte == OPC_WRITE_ARM) begin
        frameKind_r <= FK_ARM;
      end else if (linkState_r == LS_ADDR && addrSecond_r && isWriteOp_r) begin
        frameKind_r <= addrHi_r[SPACE_SEL_HI_POS] ? FK_LOCK : FK_WRITE;
      end else if (linkState_r == LS_WRDATA) begin
        dataSeen_r <= 1'b1;
        lockData_r <= rxByte[LOCK_DATA_POS]; // Lock byte needs bit 1
      end
    end
  end

  // Write data goes to mclk as address and byte; lock data stays in the summary
  always_ff @(posedge spiClk) begin
    if (byteDone && linkState_r == LS_WRDATA && !addrHi_r[SPACE_SEL_HI_POS]) begin
      xfer.srcData <= {addrCnt_r, rxByte};
      xfer.srcToggle <= ~xfer.srcToggle;
    end
  end

  // Output byte: page byte or lock-state byte, read as static data
  always_comb begin
    rdByte = page_r[addrCnt_r];
    if (linkState_r == LS_RDLOCK) begin
      rdByte = LOCK_BYTE_BASE;
      rdByte[LOCK_STATUS_POS] = locked_r;
    end
  end

  // Shift out on falling edges; released the moment csN rises
  always_ff @(negedge spiClk or posedge csN) begin
    if (csN) begin
      sdo_r <= 1'b0;
      sdoOe_r <= 1'b0; // Unselected means released
    end else if (linkState_r == LS_RDPAGE || linkState_r == LS_RDLOCK) begin
      sdoOe_r <= 1'b1;
      sdo_r <= rdByte[BIT_TOP - bitCnt_r]; // MSB first
    end
  end

  assign sdo = sdo_r;
  assign sdoOe = sdoOe_r;

  // ---- Core domain (mclk) ----

  seia_byte_sync u_byteSync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .xfer(xfer.sync)
  );

  seia_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_progTimer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(startProg),
    .busy(timerBusy),
    .done(timerDone)
  );

  // Pin and cross-domain level synchronisers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      csS1_r <= 1'b1;
      csS2_r <= 1'b1;
      csPrev_r <= 1'b1;
      supS1_r <= 1'b0;
      supS2_r <= 1'b0;
      tagS1_r <= 1'b0;
      tagS2_r <= 1'b0;
    end else begin
      csS1_r <= csN;
      csS2_r <= csS1_r;
      csPrev_r <= csS2_r;
      supS1_r <= supplyOk;
      supS2_r <= supS1_r;
      tagS1_r <= frameTag_r;
      tagS2_r <= tagS1_r;
    end
  end

  assign csRise = csS2_r && !csPrev_r;
  assign csFall = !csS2_r && csPrev_r;
  assign guardAll = blockGuardHi && blockGuardLo;
  assign frameValid = frameOk_r && (tagS2_r != tagSeen_r) && alignedEnd_r;

  // Frame judgement once the summary and last data byte have settled
  assign acceptArm = (ctlState_r == CT_SETTLE) && (settleCnt_r == 3'h0) && frameValid
    && (frameKind_r == FK_ARM);
  // Needs arm flag, at least one byte, open page and guards not both set
  assign acceptWrite = (ctlState_r == CT_SETTLE) && (settleCnt_r == 3'h0) && frameValid
    && (frameKind_r == FK_WRITE) && dataSeen_r && wel_r && !guardAll && !locked_r;
  // Lock also needs the data bit; the boundary is checked for both
  assign acceptLock = (ctlState_r == CT_SETTLE) && (settleCnt_r == 3'h0) && frameValid
    && (frameKind_r == FK_LOCK) && dataSeen_r && lockData_r && wel_r && !guardAll;
  assign startProg = acceptWrite || acceptLock; // Begins at chip select rise

  // Frame sequencing; settle only reachable when idle, so never while busy
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctlState_r <= CT_IDLE; // Standby, deselected after power-on
      settleCnt_r <= 3'h0;
    end else begin
      unique case (ctlState_r)
        CT_IDLE: begin
          if (csRise) begin
            ctlState_r <= CT_SETTLE;
            settleCnt_r <= SETTLE_CYCLES - 3'h1;
          end
        end
        CT_SETTLE: begin
          if (settleCnt_r != 3'h0) begin
            settleCnt_r <= settleCnt_r - 3'h1;
          end else if (startProg) begin
            ctlState_r <= CT_PROG;
          end else begin
            ctlState_r <= CT_IDLE;
          end
        end
        CT_PROG: begin
          if (timerDone) begin
            ctlState_r <= CT_IDLE; // Frames during the cycle are discarded
          end
        end
        default: begin
          ctlState_r <= CT_IDLE;
        end
      endcase
    end
  end

  // Frame bookkeeping: supply check at start, tag tracking while idle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      frameOk_r <= 1'b0;
      tagSeen_r <= 1'b0;
    end else begin
      if (csFall) begin
        frameOk_r <= supS2_r; // Ignore frames begun before supply is good
      end
      if (ctlState_r == CT_IDLE && csS2_r && !csRise) begin
        tagSeen_r <= tagS2_r;
      end
    end
  end

  // Arm latch: set by the arm command, consumed by an accepted write or lock
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wel_r <= 1'b0;
    end else if (acceptArm) begin
      wel_r <= 1'b1;
    end else if (startProg) begin
      wel_r <= 1'b0;
    end
  end

  // What the running cycle will do when it ends
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      progLock_r <= 1'b0;
    end else if (startProg) begin
      progLock_r <= acceptLock;
    end
  end

  // Lock is permanent: nothing ever clears it
  always_ff @(posedge mclk) begin
    if (timerDone && progLock_r) begin
      locked_r <= 1'b1;
    end
  end

  assign commitPage = timerDone && !progLock_r;
  assign maskClear = commitPage || (csFall && ctlState_r != CT_PROG);
  assign stageWr = xfer.dstValid && ctlState_r != CT_PROG;

  // Staging buffer per page byte; a byte arriving wins over a clear
  for (genvar i = 0; i < PAGE_BYTES; i++) begin : gEntry
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        pendMask_r[i] <= 1'b0;
      end else if (stageWr && xfer.dstData[XFER_W-1:BYTE_W] == PAGE_AW'(i)) begin
        pendMask_r[i] <= 1'b1;
      end else if (maskClear) begin
        pendMask_r[i] <= 1'b0;
      end
    end

    // Later bytes to the same address replace earlier ones
    always_ff @(posedge mclk) begin
      if (stageWr && xfer.dstData[XFER_W-1:BYTE_W] == PAGE_AW'(i)) begin
        pend_r[i] <= xfer.dstData[BYTE_W-1:0];
      end
    end

    // Bytes land at the end of the cycle, identification bytes included
    always_ff @(posedge mclk) begin
      if (commitPage && pendMask_r[i]) begin
        page_r[i] <= pend_r[i];
      end
    end
  end

  // Status outputs straight from flops
  assign writeLatchFlag = wel_r;
  assign busyFlag = timerBusy; // High for the whole write cycle
  assign pageLocked = locked_r;

endmodule : serial_eeprom_idpage_access

// ==== hdl/seia_pkg.sv ====
// Purpose: Shared constants and types for the identification-page access block
// Assumes: mclk at 200 MHz; SPI mode 0 (sample on rising, shift on falling edge)
// Notes: Timing counts are derived here from times in their own units
package seia_pkg;

  // Page geometry
  localparam int BYTE_W = 8;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_AW = 6;
  localparam int ID_CODE_BYTES = 3;
  localparam int XFER_W = PAGE_AW + BYTE_W;

  // Opcodes; read and lock-state read share one code, as do write and lock
  localparam logic [7:0] OPC_IDPAGE_READ = 8'h83;
  localparam logic [7:0] OPC_IDPAGE_WRITE = 8'h82;
  localparam logic [7:0] OPC_WRITE_ARM = 8'h06;

  // Address and data field positions
  localparam int SPACE_SEL_BIT = 10;
  localparam int SPACE_SEL_HI_POS = SPACE_SEL_BIT - BYTE_W;
  localparam int LOCK_DATA_POS = 1;
  localparam int LOCK_STATUS_POS = 0;
  localparam logic [2:0] BIT_TOP = 3'h7;

  // Delivery and reset values
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] LOCK_BYTE_BASE = 8'h00;
  localparam logic LOCK_DELIVERY = 1'b0;

  // Self-timed write cycle, rounded up to whole mclk cycles
  localparam int unsigned MCLK_FREQ_MHZ = 200;
  localparam int unsigned PROG_TIME_NS = 5000000;
  localparam int unsigned PROG_TIME_CYCLES = (PROG_TIME_NS * MCLK_FREQ_MHZ + 999) / 1000;

  // Wait after chip select rises so the last data byte has crossed over
  localparam logic [2:0] SETTLE_CYCLES = 3'h4;

  typedef enum logic [5:0] {
    LS_OPCODE = 6'h01,
    LS_ADDR = 6'h02,
    LS_RDPAGE = 6'h04,
    LS_RDLOCK = 6'h08,
    LS_WRDATA = 6'h10,
    LS_IGNORE = 6'h20
  } seia_link_state_type;

  typedef enum logic [2:0] {
    CT_IDLE = 3'h1,
    CT_SETTLE = 3'h2,
    CT_PROG = 3'h4
  } seia_ctl_state_type;

  typedef enum logic [1:0] {
    FK_NONE = 2'h0,
    FK_ARM = 2'h1,
    FK_WRITE = 2'h2,
    FK_LOCK = 2'h3
  } seia_frame_kind_type;

  typedef logic [BYTE_W-1:0] seia_page_type [PAGE_BYTES];

endpackage : seia_pkg

// ==== hdl/seia_xfer_if.sv ====
// Purpose: Carries write-data bytes from the SPI clock domain to mclk
// Assumes: Source holds data stable between toggles
// Notes: Toggle starts at zero so no event is seen after power-up
`timescale 1ns/1ps
interface seia_xfer_if
  import seia_pkg::*;
;
  logic srcToggle = 1'b0;
  logic [XFER_W-1:0] srcData = '0;
  logic dstValid;
  logic [XFER_W-1:0] dstData;

  modport link (output srcToggle, output srcData);
  modport sync (input srcToggle, input srcData, output dstValid, output dstData);
  modport core (input dstValid, input dstData);
endinterface : seia_xfer_if

// ==== hdl/seia_byte_sync.sv ====
// Purpose: Toggle crossing of one address/data word into mclk
// Assumes: Toggles at most once per 4 mclk cycles
// Notes: Data is sampled only after the toggle has settled, so it is stable
`timescale 1ns/1ps
module seia_byte_sync
  import seia_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  seia_xfer_if.sync xfer
);

  logic togS1_r;
  logic togS2_r;
  logic togS3_r;

  // Two-flop synchroniser plus one stage for edge detection
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      togS1_r <= 1'b0;
      togS2_r <= 1'b0;
      togS3_r <= 1'b0;
    end else begin
      togS1_r <= xfer.srcToggle;
      togS2_r <= togS1_r;
      togS3_r <= togS2_r;
    end
  end

  // One-cycle pulse with the captured word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      xfer.dstValid <= 1'b0;
      xfer.dstData <= '0;
    end else begin
      xfer.dstValid <= togS2_r ^ togS3_r;
      if (togS2_r ^ togS3_r) begin
        xfer.dstData <= xfer.srcData;
      end
    end
  end

endmodule : seia_byte_sync

// ==== hdl/seia_prog_timer.sv ====
// Purpose: Self-timed write cycle timer
// Assumes: start is a one-cycle pulse, ignored while a cycle runs
// Notes: busy rises the cycle after start; done pulses as busy falls
`timescale 1ns/1ps
module seia_prog_timer
  import seia_pkg::*;
#(
  parameter int unsigned CYCLES = PROG_TIME_CYCLES
)(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  output logic busy,
  output logic done
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

  logic [CW-1:0] count_r;

  // Count down from the load value; busy spans exactly CYCLES cycles
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy <= 1'b1;
        count_r <= LOAD;
      end else if (busy && count_r == '0) begin
        busy <= 1'b0;
        done <= 1'b1;
      end else if (busy) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : seia_prog_timer

// ==== testbench/seia_idpage_chk.sv ====
// Purpose: Port-level checks of the identification-page block
// Assumes: Every check is sampled on mclk
// Notes: Busy length is counted in helper logic, too long to unroll
`timescale 1ns/1ps
module seia_idpage_chk #(
  parameter int unsigned PROG_CYCLES = 20
)(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic spiClk,
  input wire logic csN,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdoOe,
  input wire logic supplyOk,
  input wire logic blockGuardHi,
  input wire logic blockGuardLo,
  input wire logic writeLatchFlag,
  input wire logic busyFlag,
  input wire logic pageLocked
);
  int unsigned busyCnt_r;
  // Busy cycles so far; zero while idle
  always_ff @(posedge mclk) begin
    if (sys_rst || !busyFlag) busyCnt_r <= 0;
    else busyCnt_r <= busyCnt_r + 1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_release_idle: assert property (csN |-> !sdoOe)
    else $error("data out driven while deselected");
  a_sdo_quiet: assert property (csN && $past(csN) |-> !sdo)
    else $error("data out not quiet after deselect");
  a_busy_refuse: assert property ($rose(sdoOe) |-> !busyFlag)
    else $error("read answered during write cycle");
  a_busy_len: assert property ($fell(busyFlag) |-> busyCnt_r == PROG_CYCLES)
    else $error("write cycle length wrong");
  a_busy_after_cs: assert property ($rose(busyFlag) |-> $past(csN, 5) && csN)
    else $error("write cycle began inside a frame");
  a_guard_block: assert property ($rose(busyFlag) |-> !(blockGuardHi && blockGuardLo))
    else $error("write cycle despite both guards");
  a_latch_used: assert property ($rose(busyFlag) |-> $fell(writeLatchFlag))
    else $error("latch not consumed by write");
  a_latch_set: assert property ($rose(writeLatchFlag) |-> csN && !busyFlag)
    else $error("latch set at wrong time");
  a_lock_end: assert property ($rose(pageLocked) |-> !$past(busyFlag) && $past(busyFlag, 2))
    else $error("lock not at end of cycle");
  a_lock_keep: assert property (pageLocked |=> pageLocked)
    else $error("lock was lost");
  a_reset_flags: assert property (disable iff (1'b0) sys_rst |=> !busyFlag && !writeLatchFlag)
    else $error("flags not cleared by reset");
endmodule : seia_idpage_chk

bind serial_eeprom_idpage_access seia_idpage_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .spiClk(spiClk), .csN(csN), .sdi(sdi), .sdo(sdo),
  .sdoOe(sdoOe), .supplyOk(supplyOk), .blockGuardHi(blockGuardHi),
  .blockGuardLo(blockGuardLo), .writeLatchFlag(writeLatchFlag), .busyFlag(busyFlag),
  .pageLocked(pageLocked));

// ==== testbench/seia_spi_master.sv ====
// Purpose: SPI bus master model driving one frame at a time
// Assumes: Mode 0, 12 ns link clock that runs only inside frames
// Notes: Bytes to send sit in txq; bytes seen after the header land in rxq
`timescale 1ns/1ps
module seia_spi_master (
  output logic spiClk,
  output logic csN,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdoOe
);
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic oeSeen;
  // Idle: deselected, clock parked low
  initial begin
    spiClk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
  end
  // Extra bits past the bytes cut a frame off mid-byte
  task automatic frame(input int extra);
    int n;
    logic [7:0] r;
    n = txq.size() * 8 + extra;
    rxq.delete();
    oeSeen = 1'b0;
    csN = 1'b0;
    #12;
    for (int i = 0; i < n; i++) begin
      sdi = (i / 8 < txq.size()) ? txq[i / 8][7 - i % 8] : ~sdi;
      #6 spiClk = 1'b1;
      r = {r[6:0], sdo};
      oeSeen = oeSeen | sdoOe;
      if (i % 8 == 7 && i >= 24) rxq.push_back(r);
      #6 spiClk = 1'b0;
    end
    #6 csN = 1'b1;
    sdi = ~sdi;
    #60;
  endtask : frame
endmodule : seia_spi_master

// ==== testbench/serial_eeprom_idpage_access_tb.sv ====
// Purpose: Self-checking bench for the identification-page block
// Assumes: Short write cycle via PROG_CYCLES; one master on the link
// Notes: Expected bytes come from a page model kept here
`timescale 1ns/1ps
module serial_eeprom_idpage_access_tb;
  import seia_pkg::*;
  localparam int PROG = 200;
  localparam logic [23:0] IDC = 24'h3c0f96; // Arbitrary value
  logic mclk = 1'b0, sys_rst = 1'b1, supplyOk = 1'b1, gHi = 1'b0, gLo = 1'b0;
  logic spiClk, csN, sdi, sdo, sdoOe, wlf, busy, locked, lk;
  int error_cnt = 0, num_checks = 0, seed = 32'h26464ac8, a;
  logic [7:0] model[64];
  logic [7:0] dq[$];
  initial forever #2.5 mclk = ~mclk;
  serial_eeprom_idpage_access #(.PROG_CYCLES(PROG), .DEVICE_ID_CODE(IDC)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .spiClk(spiClk), .csN(csN), .sdi(sdi), .sdo(sdo),
    .sdoOe(sdoOe), .supplyOk(supplyOk), .blockGuardHi(gHi), .blockGuardLo(gLo),
    .writeLatchFlag(wlf), .busyFlag(busy), .pageLocked(locked));
  seia_spi_master m (.spiClk(spiClk), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // Page or lock-state read; don't-care address bits sent as ones
  task automatic rd(input int a0, input int n, input logic ls);
    m.txq = {OPC_IDPAGE_READ, ls ? 8'hff : 8'hfb, 8'hc0 | 8'(a0)};
    repeat (n) m.txq.push_back(8'h00);
    m.frame(0);
    for (int k = 0; k < n; k++) chk(m.rxq[k], ls ? {7'h0, lk} : model[a0 + k]);
  endtask : rd
  // Arm, then write or lock with nd random data bytes
  task automatic cmd(input logic [7:0] hi, input logic [7:0] lo, input int nd, input int extra);
    m.txq = {OPC_WRITE_ARM};
    m.frame(0);
    chk(8'(wlf), 8'h01);
    dq.delete();
    repeat (nd) dq.push_back(8'($random(seed)));
    // Address bit 8 is a don't-care, so it picks a bad lock byte here
    if (hi[2]) dq[0][1] = !hi[0];
    m.txq = {OPC_IDPAGE_WRITE, hi, lo};
    foreach (dq[k]) m.txq.push_back(dq[k]);
    m.frame(extra);
  endtask : cmd
  initial begin
    #100us;
    error_cnt++;
    summarize();
  end
  initial begin
    for (int i = 0; i < 64; i++) model[i] = (i < 3) ? IDC[23 - 8 * i -: 8] : 8'hff;
    lk = 1'b0;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    rd(0, 5, 0);
    rd(61, 3, 0);
    rd(0, 3, 1);
    $display("test reads done");
    m.txq = {OPC_IDPAGE_WRITE, 8'h00, 8'h05, 8'haa};
    m.frame(0);
    chk(8'(busy), 8'h00);
    for (int g = 0; g < 4; g++) begin
      @(negedge mclk);
      gHi = g[1];
      gLo = g[0];
      a = (g == 0) ? 0 : ($random(seed) & 31) + 3;
      cmd(8'hfb, 8'hc0 | 8'(a), 3, 0);
      chk(8'(busy), 8'(g != 3));
      if (g != 3) begin
        foreach (dq[k]) model[(a + k) % 64] = dq[k];
        chk(8'(wlf), 8'h00);
        m.txq = {OPC_IDPAGE_READ, 8'h00, 8'h00, 8'h00};
        m.frame(0);
        chk(8'(m.oeSeen), 8'h00);
        repeat (PROG) @(negedge mclk);
        chk(8'(busy), 8'h00);
        rd(a, 3, 0);
      end
    end
    @(negedge mclk);
    gHi = 1'b0;
    gLo = 1'b0;
    $display("test writes done");
    cmd(8'h00, 8'h09, 1, 3);
    chk(8'(busy), 8'h00);
    cmd(8'h04, 8'h00, 1, 5);
    chk(8'(busy), 8'h00);
    rd(9, 1, 0);
    cmd(8'h05, 8'h00, 1, 0);
    chk(8'(busy), 8'h00);
    cmd(8'h04, 8'h00, 1, 0);
    chk(8'(busy), 8'h01);
    repeat (PROG) @(negedge mclk);
    lk = 1'b1;
    chk(8'(locked), 8'h01);
    rd(0, 2, 1);
    cmd(8'h00, 8'h0a, 1, 0);
    chk(8'(busy), 8'h00);
    rd(10, 1, 0);
    $display("test lock done");
    @(negedge mclk);
    sys_rst = 1'b1;
    supplyOk = 1'b0;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    m.txq = {OPC_WRITE_ARM};
    m.frame(0);
    chk(8'(wlf), 8'h00);
    chk(8'(locked), 8'h01);
    @(negedge mclk);
    supplyOk = 1'b1;
    repeat (4) @(negedge mclk);
    rd(0, 3, 0);
    $display("test power-on done");
    summarize();
  end
endmodule : serial_eeprom_idpage_access_tb
